// >>> rtl/iwc_pkg.sv
package iwc_pkg;

  // data-space addresses of the option register and the block status register
  localparam logic [7:0] IWC_OPT_ADDR    = 8'hc8;  // interrupt_option_control, write only
  localparam logic [7:0] IWC_STATUS_ADDR = 8'hcf;  // read-only status of this block
  localparam logic [7:0] IWC_OPT_RESET   = 8'h00;  // option register after reset
  localparam logic [7:0] IWC_OPT_WMASK   = 8'h70;  // only bits 6..4 are stored
  localparam logic [7:0] IWC_RDATA_IDLE  = 8'h00;  // read data outside a read answer

  // option register field positions
  localparam int IWC_SENSE_BIT = 6;  // sense_select_bit
  localparam int IWC_POL_BIT   = 5;  // polarity_bit
  localparam int IWC_ENA_BIT   = 4;  // global_enable

  // status register field positions (bits 4..0 carry the vector requests)
  localparam int IWC_ST_HALT_BIT = 5;  // core halted in wait, stop or stabilisation
  localparam int IWC_ST_STAB_BIT = 6;  // oscillator stabilisation running

  // vector numbers, also bit positions of the request vector
  localparam int IWC_VEC_NMI = 0;
  localparam int IWC_VEC_1   = 1;
  localparam int IWC_VEC_2   = 2;
  localparam int IWC_VEC_3   = 3;
  localparam int IWC_VEC_4   = 4;
  localparam int IWC_NUM_VEC = 5;

  // oscillator stabilisation after stop, in system clock cycles
  localparam logic [11:0] IWC_STAB_CYCLES = 12'd2048;
  localparam logic [11:0] IWC_STAB_ONE    = 12'd1;
  localparam logic [11:0] IWC_STAB_ZERO   = 12'd0;

  // power state, one-hot
  typedef enum logic [3:0] {
    IWC_PS_RUN  = 4'b0001,  // executing
    IWC_PS_WAIT = 4'b0010,  // clock running, core frozen
    IWC_PS_STOP = 4'b0100,  // oscillator halted
    IWC_PS_STAB = 4'b1000   // waiting for the oscillator after stop
  } iwc_pstate_t;

  // peripheral events, active high levels from their flags
  typedef struct packed {
    logic timer_overflow_event;
    logic conversion_done_event;
    logic reload_overflow_event;
    logic reload_compare_event;
    logic reload_edge_event;
    logic serial_done_event;
  } iwc_periph_ev_t;

  // per-event mask bits held in the peripherals
  typedef struct packed {
    logic timer_overflow_mask;
    logic conversion_done_mask;
    logic reload_overflow_mask;
    logic reload_compare_mask;
    logic reload_edge_mask;
    logic serial_done_mask;
  } iwc_periph_mask_t;

  // one 8-bit port: direction, option, data registers and pin levels
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] opt;
    logic [7:0] data;
    logic [7:0] pins;
  } iwc_port_t;

endpackage

// >>> rtl/iwc_edge_latch.sv
`timescale 1ns/1ps
// edge-triggered request latch: first edge is held until the routine starts
module iwc_edge_latch (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_reset,    // synchronous reset, active high
  input  wire logic i_line,     // source line level, idle high
  input  wire logic i_rise,     // 1 = rising edge, 0 = falling edge
  input  wire logic i_clear,    // routine start acknowledge
  output logic      o_pend      // latched request
);

  logic line_q;  // previous line level
  logic pend_q;  // request latch
  logic evt;     // selected edge this cycle

  // line idles high, so reset to one keeps reset release free of false edges
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      line_q <= 1'b1;
    end else begin
      line_q <= i_line;
    end
  end

  assign evt = i_rise ? (i_line & ~line_q) : (~i_line & line_q);

  // a new edge in the clearing cycle wins, so that request is not lost
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= evt | (pend_q & ~i_clear);
    end
  end

  assign o_pend = pend_q;

endmodule

// >>> rtl/iwc_intc.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Function
// - option register at C8, write-only, resets zero
// - unused option bits have no effect
// - bit 6 selects level or edge, source one
// - bit 5 selects source two edge polarity
// - polarity one rising, zero falling
// - bit 4 enables all maskable sources
// - non-maskable serviced, but no wake when disabled
// - timer overflow and conversion done to vector 4
// - three reload timer events onto vector 3
// - serial done event onto vector 2
// - ports A/B vector 1, port C vector 2
// - wait halts core, clock keeps running
// - wake from wait without stabilisation delay
// - stop only without watchdog, oscillator halts
// - stop with watchdog active acts as wait
// - wake from stop inserts stabilisation delay
// - reset ends wait or stop
// - wake leaves oscillator selection unchanged
// - main-program wake services handler, then continues
// - wake inside non-maskable handler resumes next instruction
// - low-power instruction skipped while request pending
module iwc_intc (
  input  wire logic                      i_clk_sys,      // system clock, 200 MHz
  input  wire logic                      i_reset,        // synchronous reset, active high
  input  wire logic [7:0]                i_addr,         // register address
  input  wire logic [7:0]                i_wdata,        // register write data
  input  wire logic                      i_wr,           // write strobe
  input  wire logic                      i_rd,           // read strobe
  output logic      [7:0]                o_rdata,        // read data, cycle after strobe
  input  wire logic                      i_nmi_n,        // non-maskable pin, falling edge
  input  wire iwc_pkg::iwc_port_t        i_port_a,       // port A registers and pins
  input  wire iwc_pkg::iwc_port_t        i_port_b,       // port B registers and pins
  input  wire iwc_pkg::iwc_port_t        i_port_c,       // port C registers and pins
  input  wire iwc_pkg::iwc_periph_ev_t   i_periph_ev,    // peripheral event flags
  input  wire iwc_pkg::iwc_periph_mask_t i_periph_mask,  // peripheral mask bits
  input  wire logic [4:0]                i_ack,          // core starts routine of vector n
  input  wire logic                      i_wait_exec,    // core executes wait
  input  wire logic                      i_stop_exec,    // core executes stop
  input  wire logic                      i_in_nmi,       // core is in non-maskable mode
  input  wire logic                      i_wdog_active,  // watchdog running
  output logic [4:0]                     o_irq_req,      // requests to core, bit = vector
  output logic                           o_core_halt,    // core must not execute
  output logic                           o_osc_stop,     // oscillator halted
  output logic                           o_wake,         // pulse: core resumes
  output logic                           o_resume_next,  // pulse: resume next instr
  output logic                           o_lp_skip       // pulse: low-power instr skipped
);

  // option register and its fields
  logic [7:0]          opt_q;        // interrupt_option_control
  logic                sense_select_bit;
  logic                polarity_bit;
  logic                global_enable;

  // source lines, idle high, low while some enabled pin is low
  logic [7:0]          pin_en_a;     // pin interrupt enables per port
  logic [7:0]          pin_en_b;
  logic [7:0]          pin_en_c;
  logic                line1;        // source one line (ports A and B)
  logic                line2;        // source two line (port C and serial)
  logic                line2_q;      // previous source two line, for checks

  // requests
  logic                nmi_pend;
  logic                src1_edge;
  logic                src2_pend;
  logic                req1_raw;
  logic                req3_raw;
  logic                req4_raw;
  logic [4:0]          req;          // requests after the global enable
  logic                pending;      // any enabled request
  logic                wake_req;     // wake condition

  // power control
  iwc_pkg::iwc_pstate_t state_q;
  iwc_pkg::iwc_pstate_t state_d;
  logic [11:0]         stab_q;       // stabilisation countdown
  logic                nmi_ctx_q;    // low-power entered inside non-maskable handler
  logic                lp_cmd;       // wait or stop executed this cycle
  logic                wake_q;
  logic                resume_q;
  logic                skip_q;
  logic [7:0]          rdata_q;
  logic [7:0]          status;

  // register write port: only bits 6..4 are kept, so unused bits can never act
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      opt_q <= iwc_pkg::IWC_OPT_RESET;
    end else if (i_wr && (i_addr == iwc_pkg::IWC_OPT_ADDR)) begin
      opt_q <= i_wdata & iwc_pkg::IWC_OPT_WMASK;
    end
  end

  assign sense_select_bit = opt_q[iwc_pkg::IWC_SENSE_BIT];
  assign polarity_bit     = opt_q[iwc_pkg::IWC_POL_BIT];
  assign global_enable    = opt_q[iwc_pkg::IWC_ENA_BIT];

  // status byte: vector requests, halt and stabilisation flags
  always_comb begin
    status = 8'h00;
    status[4:0] = req;
    status[iwc_pkg::IWC_ST_HALT_BIT] = o_core_halt;
    status[iwc_pkg::IWC_ST_STAB_BIT] = (state_q == iwc_pkg::IWC_PS_STAB);
  end

  // read port; the option register reads as zero since it is write-only,
  // which is why a bit set or clear on it cannot work
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_q <= iwc_pkg::IWC_RDATA_IDLE;
    end else if (i_rd && (i_addr == iwc_pkg::IWC_STATUS_ADDR)) begin
      rdata_q <= status;
    end else begin
      rdata_q <= iwc_pkg::IWC_RDATA_IDLE;
    end
  end

  assign o_rdata = rdata_q;

  // a pin joins the interrupt system as input, option set, data clear
  assign pin_en_a = ~i_port_a.dir & i_port_a.opt & ~i_port_a.data;
  assign pin_en_b = ~i_port_b.dir & i_port_b.opt & ~i_port_b.data;
  assign pin_en_c = ~i_port_c.dir & i_port_c.opt & ~i_port_c.data;

  // ports A and B share source one; port C and the serial event share source two
  assign line1 = &((~pin_en_a | i_port_a.pins) & (~pin_en_b | i_port_b.pins));
  assign line2 = &(~pin_en_c | i_port_c.pins) &
                 ~(i_periph_ev.serial_done_event & i_periph_mask.serial_done_mask);

  // non-maskable request: falling edge, latched until its routine starts
  iwc_edge_latch u_nmi_latch (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_line    (i_nmi_n),
    .i_rise    (1'b0),
    .i_clear   (i_ack[iwc_pkg::IWC_VEC_NMI]),
    .o_pend    (nmi_pend)
  );

  // source one edge mode always detects the falling edge
  iwc_edge_latch u_src1_latch (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_line    (line1),
    .i_rise    (1'b0),
    .i_clear   (i_ack[iwc_pkg::IWC_VEC_1]),
    .o_pend    (src1_edge)
  );

  // source two is always edge sensitive, polarity from the option register
  iwc_edge_latch u_src2_latch (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_line    (line2),
    .i_rise    (polarity_bit),
    .i_clear   (i_ack[iwc_pkg::IWC_VEC_2]),
    .o_pend    (src2_pend)
  );

  // level mode has no storage: the request lasts only while the line is low
  assign req1_raw = sense_select_bit ? ~line1 : src1_edge;

  // sources three and four are plain levels of masked events
  assign req3_raw = (i_periph_ev.reload_overflow_event & i_periph_mask.reload_overflow_mask) |
                    (i_periph_ev.reload_compare_event  & i_periph_mask.reload_compare_mask)  |
                    (i_periph_ev.reload_edge_event     & i_periph_mask.reload_edge_mask);
  assign req4_raw = (i_periph_ev.timer_overflow_event  & i_periph_mask.timer_overflow_mask) |
                    (i_periph_ev.conversion_done_event & i_periph_mask.conversion_done_mask);

  // global enable gates every source except the non-maskable one
  always_comb begin
    req = 5'h00;
    req[iwc_pkg::IWC_VEC_NMI] = nmi_pend;
    req[iwc_pkg::IWC_VEC_1]   = global_enable & req1_raw;
    req[iwc_pkg::IWC_VEC_2]   = global_enable & src2_pend;
    req[iwc_pkg::IWC_VEC_3]   = global_enable & req3_raw;
    req[iwc_pkg::IWC_VEC_4]   = global_enable & req4_raw;
  end

  assign o_irq_req = req;
  assign pending   = |req;
  // with the enable low nothing wakes the core, the non-maskable one included
  assign wake_req  = global_enable & pending;
  assign lp_cmd    = i_wait_exec | i_stop_exec;

  // power state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      iwc_pkg::IWC_PS_RUN: begin
        if (lp_cmd && !pending) begin
          if (i_stop_exec && !i_wdog_active) begin
            state_d = iwc_pkg::IWC_PS_STOP;
          end else begin
            state_d = iwc_pkg::IWC_PS_WAIT;
          end
        end
      end
      iwc_pkg::IWC_PS_WAIT: begin
        if (wake_req) begin
          state_d = iwc_pkg::IWC_PS_RUN;
        end
      end
      iwc_pkg::IWC_PS_STOP: begin
        if (wake_req) begin
          state_d = iwc_pkg::IWC_PS_STAB;
        end
      end
      iwc_pkg::IWC_PS_STAB: begin
        if (stab_q == iwc_pkg::IWC_STAB_ONE) begin
          state_d = iwc_pkg::IWC_PS_RUN;
        end
      end
      default: begin
        state_d = iwc_pkg::IWC_PS_RUN;                         // illegal code recovers
      end
    endcase
  end

  // reset always returns to run, whatever low-power state was active
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q <= iwc_pkg::IWC_PS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // stabilisation countdown, loaded on the wake from stop
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stab_q <= iwc_pkg::IWC_STAB_ZERO;
    end else if (state_q == iwc_pkg::IWC_PS_STOP && wake_req) begin
      stab_q <= iwc_pkg::IWC_STAB_CYCLES;
    end else if (stab_q != iwc_pkg::IWC_STAB_ZERO) begin
      stab_q <= stab_q - iwc_pkg::IWC_STAB_ONE;
    end
  end

  // remember whether low power was entered from the non-maskable handler
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      nmi_ctx_q <= 1'b0;
    end else if (state_q == iwc_pkg::IWC_PS_RUN && lp_cmd && !pending) begin
      nmi_ctx_q <= i_in_nmi;
    end
  end

  // wake, resume and skip pulses; requests stay on o_irq_req after a
  // main-program wake, so the core vectors to the handler first
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wake_q   <= 1'b0;
      resume_q <= 1'b0;
      skip_q   <= 1'b0;
    end else begin
      wake_q   <= (state_q != iwc_pkg::IWC_PS_RUN) && (state_d == iwc_pkg::IWC_PS_RUN);
      resume_q <= (state_q != iwc_pkg::IWC_PS_RUN) && (state_d == iwc_pkg::IWC_PS_RUN) &&
                  nmi_ctx_q;
      skip_q   <= (state_q == iwc_pkg::IWC_PS_RUN) && lp_cmd && pending;
    end
  end

  // oscillator only stops; its source selection lives elsewhere and a wake
  // never touches it
  assign o_osc_stop    = (state_q == iwc_pkg::IWC_PS_STOP);
  assign o_core_halt   = (state_q != iwc_pkg::IWC_PS_RUN);
  assign o_wake        = wake_q;
  assign o_resume_next = resume_q;
  assign o_lp_skip     = skip_q;

  // helper: previous source two line for the edge check
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      line2_q <= 1'b1;
    end else begin
      line2_q <= line2;
    end
  end

  // checks
  property p_opt_read_zero;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_rd && i_addr == iwc_pkg::IWC_OPT_ADDR) |=> (o_rdata == iwc_pkg::IWC_RDATA_IDLE);
  endproperty
  a_opt_read_zero: assert property (p_opt_read_zero) else $error("option register read not zero");

  property p_unused_bits;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_wr && i_addr == iwc_pkg::IWC_OPT_ADDR) |=>
        (opt_q == ($past(i_wdata) & iwc_pkg::IWC_OPT_WMASK));
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused option bits stored");

  property p_level_mode;
    @(posedge i_clk_sys) disable iff (i_reset)
      (sense_select_bit && global_enable && !line1) |-> o_irq_req[1];
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("level request on source one missing");

  property p_rise_edge;
    @(posedge i_clk_sys) disable iff (i_reset)
      (polarity_bit && line2 && !line2_q && global_enable) |=> o_irq_req[2];
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge on source two lost");

  property p_ena_masks;
    @(posedge i_clk_sys) disable iff (i_reset)
      !global_enable |-> (o_irq_req[4:1] == 4'h0);
  endproperty
  a_ena_masks: assert property (p_ena_masks) else $error("maskable request while disabled");

  property p_nmi_no_wake;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_WAIT && !global_enable) |=> (state_q == iwc_pkg::IWC_PS_WAIT);
  endproperty
  a_nmi_no_wake: assert property (p_nmi_no_wake) else $error("wake while globally disabled");

  property p_vec4;
    @(posedge i_clk_sys) disable iff (i_reset)
      (global_enable && i_periph_ev.timer_overflow_event && i_periph_mask.timer_overflow_mask)
        |-> o_irq_req[4];
  endproperty
  a_vec4: assert property (p_vec4) else $error("timer overflow not on vector 4");

  property p_wait_wake;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_WAIT && wake_req) |=> (!o_core_halt && o_wake);
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("wait wake not immediate");

  property p_stop_as_wait;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_RUN && i_stop_exec && i_wdog_active && !pending)
        |=> (state_q == iwc_pkg::IWC_PS_WAIT && !o_osc_stop);
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) else $error("stop not turned into wait");

  property p_stop_stab;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_STOP && wake_req) |=> (o_core_halt && !o_wake) [*8];
  endproperty
  a_stop_stab: assert property (p_stop_stab) else $error("no stabilisation after stop");

  property p_skip;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_RUN && lp_cmd && pending) |=> (o_lp_skip && !o_core_halt);
  endproperty
  a_skip: assert property (p_skip) else $error("low-power entered with request pending");

  property p_cov_wait;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_WAIT) ##1 o_wake;
  endproperty
  c_cov_wait: cover property (p_cov_wait);

  property p_cov_stop;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_q == iwc_pkg::IWC_PS_STAB) ##1 (state_q == iwc_pkg::IWC_PS_RUN);
  endproperty
  c_cov_stop: cover property (p_cov_stop);

  property p_cov_skip;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_lp_skip;
  endproperty
  c_cov_skip: cover property (p_cov_skip);

  property p_cov_resume;
    @(posedge i_clk_sys) disable iff (i_reset)
      o_resume_next;
  endproperty
  c_cov_resume: cover property (p_cov_resume);

endmodule

// >>> sim/iwc_core_model.sv
`timescale 1ns/1ps
// core stand-in: starts the routine of the lowest pending vector, slowly
module iwc_core_model (
  input  wire logic       i_clk_sys,  // system clock
  input  wire logic       i_reset,    // synchronous reset, active high
  input  wire logic       i_auto,     // 1 = service requests
  input  wire logic       i_halt,     // core frozen in low power
  input  wire logic [4:0] i_req,      // vector requests
  output logic      [4:0] o_ack       // routine start, one-cycle pulse
);
  logic [1:0] dly_q;  // waits two cycles, like an instruction end
  // a frozen core never acknowledges, so requests pile up while halted
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_auto || i_halt || i_req == 5'h00) begin
      o_ack <= 5'h00;
      dly_q <= 2'h0;
    end else if (dly_q == 2'h2) begin
      o_ack <= i_req & (~i_req + 5'h01);  // lowest vector has top priority
      dly_q <= 2'h0;
    end else begin
      o_ack <= 5'h00;
      dly_q <= dly_q + 2'h1;
    end
  end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("FAIL %s exp %h got %h", nm, e, a); end end
module testbench;
  logic                      clk, rst, wr, rd, nmi_n, wt, st, innmi, wd, aut;
  logic [7:0]                addr, wdata, rdata, d;
  iwc_pkg::iwc_port_t        pa, pb, pc;
  iwc_pkg::iwc_periph_ev_t   ev;
  iwc_pkg::iwc_periph_mask_t msk;
  logic [4:0]                ack, irq;
  logic                      halt, osc, wake, rnext, skip;
  int                        fails, n_compared, cyc;
  int                        vt[6] = '{2, 3, 3, 3, 4, 4};  // vector of each event bit

  iwc_intc iwc_intc_inst (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_nmi_n(nmi_n), .i_port_a(pa), .i_port_b(pb),
    .i_port_c(pc), .i_periph_ev(ev), .i_periph_mask(msk), .i_ack(ack), .i_wait_exec(wt),
    .i_stop_exec(st), .i_in_nmi(innmi), .i_wdog_active(wd), .o_irq_req(irq),
    .o_core_halt(halt), .o_osc_stop(osc), .o_wake(wake), .o_resume_next(rnext),
    .o_lp_skip(skip));
  iwc_core_model iwc_core_model_inst (.i_clk_sys(clk), .i_reset(rst), .i_auto(aut),
    .i_halt(halt), .i_req(irq), .o_ack(ack));

  // clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard: the longest path is one stop wake of about 2k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // reset for 8 cycles with every source idle (lines high, pins not enabled)
  task automatic do_rst();
    @(posedge clk);
    {rst, wr, rd, wt, st, innmi, wd, aut, nmi_n} <= 9'h101;
    {ev, msk} <= 12'h000;
    pa <= 32'h0000_00ff; pb <= 32'h0000_00ff; pc <= 32'h0000_00ff;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_regs();
    do_rst(); reg_wr(8'hc8, 8'h70); msk <= '1; ev <= 6'h20;
    reg_rd(8'hc8); `CHK("option read", 8'h00, d)
    reg_rd(8'h55); `CHK("unmapped", 8'h00, d)
    reg_rd(8'hcf); `CHK("status req", 5'h10, d[4:0])
  endtask
  // level events per mask, then the serial edge onto vector 2
  task automatic t_periph();
    do_rst(); msk <= '1; ev <= 6'h20;
    @(posedge clk); #1 `CHK("enable off", 5'h00, irq)
    reg_wr(8'hc8, 8'h10);
    for (int i = 5; i >= 1; i--) begin
      @(posedge clk); ev <= 6'(1 << i); msk <= ~6'(1 << i);
      @(posedge clk); #1 `CHK("masked", 5'h00, irq)
      @(posedge clk); msk <= '1;
      @(posedge clk); #1 `CHK("vector", 5'(1 << vt[i]), irq)
    end
    @(posedge clk); ev <= 6'h01;
    repeat (2) @(posedge clk); #1 `CHK("serial", 5'h04, irq)
  endtask
  task automatic t_ports();
    do_rst(); reg_wr(8'hc8, 8'h50);  // level sense on source one
    @(posedge clk); pa.opt <= 8'h01; pa.pins <= 8'hfe;
    @(posedge clk); #1 `CHK("port a", 5'h02, irq)
    @(posedge clk); pa.pins <= 8'hff; pb.opt <= 8'h80; pb.pins <= 8'h7f;
    @(posedge clk); #1 `CHK("port b", 5'h02, irq)
    @(posedge clk); pb.pins <= 8'hff;
    @(posedge clk); #1 `CHK("level off", 5'h00, irq)
    for (int p = 0; p < 2; p++) begin
      do_rst(); reg_wr(8'hc8, (p == 1) ? 8'h30 : 8'h9f);  // junk in unused bits on the falling-edge pass (p == 0)
      @(posedge clk); pc.opt <= 8'h01; pc.pins <= 8'hfe;
      repeat (2) @(posedge clk); #1 `CHK("fall", 1'(p == 0), irq[2])
      @(posedge clk); pc.pins <= 8'hff;
      repeat (2) @(posedge clk); #1 `CHK("rise", 1'b1, irq[2])
    end
  endtask
  // wait from main program, then from the non-maskable routine
  task automatic t_wait();
    for (int n = 0; n < 2; n++) begin
      do_rst(); reg_wr(8'hc8, 8'h10); msk <= '1; innmi <= 1'(n);
      @(posedge clk); wt <= 1'b1;
      @(posedge clk); wt <= 1'b0;
      #1 `CHK("wait halt", 2'b10, {halt, osc})
      repeat (3) @(posedge clk); ev <= 6'h20;
      @(posedge clk); #1 `CHK("wait wake", 2'b10, {wake, halt})
      `CHK("resume next", 1'(n), rnext)
    end
  endtask
  task automatic t_stop();
    do_rst(); reg_wr(8'hc8, 8'h10); msk <= '1;
    @(posedge clk); st <= 1'b1;
    @(posedge clk); st <= 1'b0;
    #1 `CHK("stop osc", 1'b1, osc)
    @(posedge clk); ev <= 6'h20;
    @(posedge clk); #1 `CHK("stab", 2'b01, {osc, halt})
    reg_rd(8'hcf); `CHK("stab status", 8'h70, d)
    repeat (2045) @(posedge clk); #1 `CHK("stab end", 1'b1, halt)
    @(posedge clk); #1 `CHK("stop wake", 2'b10, {wake, halt})
    @(posedge clk); ev <= 6'h00; wd <= 1'b1; st <= 1'b1;
    @(posedge clk); st <= 1'b0;
    #1 `CHK("stop as wait", 2'b01, {osc, halt})
    @(posedge clk); ev <= 6'h20;
    @(posedge clk); #1 `CHK("fast wake", 1'b1, wake)
  endtask
  task automatic t_skip();
    do_rst(); reg_wr(8'hc8, 8'h10); msk <= '1;
    @(posedge clk); ev <= 6'h20; wt <= 1'b1;
    @(posedge clk); wt <= 1'b0;
    #1 `CHK("skip", 2'b10, {skip, halt})
  endtask
  // global enable low: no wake from nmi, reset ends wait, nmi still serviced
  task automatic t_nmi();
    do_rst();
    @(posedge clk); wt <= 1'b1;
    @(posedge clk); wt <= 1'b0; nmi_n <= 1'b0;
    repeat (4) @(posedge clk); #1 `CHK("nmi no wake", 2'b11, {irq[0], halt})
    @(posedge clk); rst <= 1'b1;
    @(posedge clk); rst <= 1'b0; aut <= 1'b1; nmi_n <= 1'b1;
    #1 `CHK("reset exit", 1'b0, halt)
    @(posedge clk); nmi_n <= 1'b0;
    @(posedge clk); #1 `CHK("nmi latched", 1'b1, irq[0])
    repeat (10) @(posedge clk); #1 `CHK("nmi served", 1'b0, irq[0])
  endtask
  initial begin
    {rst, wr, rd, nmi_n, wt, st, innmi, wd, aut} = 9'h120;
    {addr, wdata, ev, msk} = 28'h0;
    pa = 32'h0000_00ff; pb = 32'h0000_00ff; pc = 32'h0000_00ff;
    t_regs(); t_periph(); t_ports(); t_wait(); t_stop(); t_skip(); t_nmi();
    conclude();
  end
endmodule
